// >>> hdl/iacl_matcher.sv
/*
  ipv4 filter_entry matcher: decides whether a parsed ingress frame
  hits one access control entry, using protocol, time-to-live,
  fragmentation, options, source_address_criterion and
  destination_address_criterion. verdict comes two cycles later.
  assumes the frame parser presents a whole header with frame_valid for
  one cycle, and that management holds cfg stable around a frame.
  the icmp and tcp/udp port checks live outside and arrive as l4_ok.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iacl_params.svh"

module iacl_matcher
  import iacl_pkg::*;
#(
  parameter int CNT_W = `IACL_CNT_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // frame from the ingress parser
  input wire logic frame_valid,
  input wire iacl_frame_t frame,
  // filter_entry configuration from management
  input wire iacl_cfg_t cfg,
  // verdict to the forwarding logic
  output logic verdict_valid,
  output logic verdict_hit,
  output iacl_result_t verdict_detail,
  // status for management
  output logic [CNT_W-1:0] hit_count
);

  // stage one: registered per-criterion outcomes
  logic s1_valid_r;
  logic type_ok_r;
  logic type_ok_nxt;
  logic proto_ok_r;
  logic proto_ok_nxt;
  logic ttl_ok_r;
  logic ttl_ok_nxt;
  logic frag_ok_r;
  logic frag_ok_nxt;
  logic opt_ok_r;
  logic opt_ok_nxt;
  logic [`IACL_NUM_ADDR-1:0] addr_ok_r;
  logic [`IACL_NUM_ADDR-1:0] addr_ok_nxt;

  // stage two: the verdict itself
  logic verdict_valid_r;
  logic verdict_hit_r;
  logic verdict_hit_nxt;
  iacl_result_t detail_r;
  iacl_result_t detail_nxt;
  logic [CNT_W-1:0] hit_count_r;

  // address criteria laid out per slot for the generate loop
  iacl_addr_mode_t addr_mode [`IACL_NUM_ADDR];
  logic [`IACL_ADDR_W-1:0] addr_cfg [`IACL_NUM_ADDR];
  logic [`IACL_ADDR_W-1:0] addr_mask [`IACL_NUM_ADDR];
  logic [`IACL_ADDR_W-1:0] addr_frame [`IACL_NUM_ADDR];

  // derived header facts
  logic ttl_nonzero;
  logic is_fragment;
  logic applies;

  // an ipv4 entry gates every criterion below; other entries pass
  assign applies = cfg.entry_is_ipv4;
  assign ttl_nonzero = (frame.ttl != `IACL_TTL_ZERO);
  assign is_fragment = frame.more_frag
                     | (frame.frag_off != `IACL_FRAG_OFF_ZERO);

  // map the two address criteria onto slots
  assign addr_mode[`IACL_SLOT_SRC] = cfg.src_mode;
  assign addr_cfg[`IACL_SLOT_SRC] = cfg.src_addr;
  assign addr_mask[`IACL_SLOT_SRC] = cfg.src_mask;
  assign addr_frame[`IACL_SLOT_SRC] = frame.src_addr;
  assign addr_mode[`IACL_SLOT_DST] = cfg.dst_mode;
  assign addr_cfg[`IACL_SLOT_DST] = cfg.dst_addr;
  assign addr_mask[`IACL_SLOT_DST] = cfg.dst_mask;
  assign addr_frame[`IACL_SLOT_DST] = frame.dst_addr;

  // frame type: an ipv4 entry only hits ipv4 frames
  always_comb begin
    type_ok_nxt = 1'b1;
    if (applies) begin
      type_ok_nxt = frame.is_ipv4;
    end
  end

  // protocol filter; layer four criteria ride along in the l4 modes
  always_comb begin
    proto_ok_nxt = 1'b1;
    if (applies) begin
      case (cfg.proto_mode)
        IACL_PROTO_ANY: begin
          proto_ok_nxt = 1'b1;
        end
        IACL_PROTO_SPECIFIC: begin
          proto_ok_nxt = (frame.proto == cfg.proto_val);
        end
        IACL_PROTO_MODE_ICMP: begin
          proto_ok_nxt = (frame.proto == `IACL_PROTO_ICMP)
                       & frame.l4_ok;
        end
        IACL_PROTO_MODE_UDP: begin
          proto_ok_nxt = (frame.proto == `IACL_PROTO_UDP)
                       & frame.l4_ok;
        end
        IACL_PROTO_MODE_TCP: begin
          proto_ok_nxt = (frame.proto == `IACL_PROTO_TCP)
                       & frame.l4_ok;
        end
        default: begin
          proto_ok_nxt = 1'b0; // unknown encodings never hit
        end
      endcase
    end
  end

  // time-to-live: no means zero only, yes means non-zero only
  always_comb begin
    ttl_ok_nxt = 1'b1;
    if (applies) begin
      case (cfg.ttl_mode)
        IACL_TRI_ANY: begin
          ttl_ok_nxt = 1'b1;
        end
        IACL_TRI_NO: begin
          ttl_ok_nxt = !ttl_nonzero;
        end
        IACL_TRI_YES: begin
          ttl_ok_nxt = ttl_nonzero;
        end
        default: begin
          ttl_ok_nxt = 1'b0;
        end
      endcase
    end
  end

  // fragmentation: more-fragments bit or a nonzero offset
  always_comb begin
    frag_ok_nxt = 1'b1;
    if (applies) begin
      case (cfg.frag_mode)
        IACL_TRI_ANY: begin
          frag_ok_nxt = 1'b1;
        end
        IACL_TRI_NO: begin
          frag_ok_nxt = !is_fragment;
        end
        IACL_TRI_YES: begin
          frag_ok_nxt = is_fragment;
        end
        default: begin
          frag_ok_nxt = 1'b0;
        end
      endcase
    end
  end

  // ip options flag
  always_comb begin
    opt_ok_nxt = 1'b1;
    if (applies) begin
      case (cfg.opt_mode)
        IACL_TRI_ANY: begin
          opt_ok_nxt = 1'b1;
        end
        IACL_TRI_NO: begin
          opt_ok_nxt = !frame.has_options;
        end
        IACL_TRI_YES: begin
          opt_ok_nxt = frame.has_options;
        end
        default: begin
          opt_ok_nxt = 1'b0;
        end
      endcase
    end
  end

  // source and destination address criteria share one comparator form
  for (genvar k = 0; k < `IACL_NUM_ADDR; k++) begin : g_addr
    always_comb begin
      addr_ok_nxt[k] = 1'b1;
      if (applies) begin
        case (addr_mode[k])
          IACL_ADDR_ANY: begin
            addr_ok_nxt[k] = 1'b1;
          end
          IACL_ADDR_HOST: begin
            addr_ok_nxt[k] = (addr_frame[k] == addr_cfg[k]);
          end
          IACL_ADDR_NETWORK: begin
            addr_ok_nxt[k] = ((addr_frame[k] & addr_mask[k])
                           == (addr_cfg[k] & addr_mask[k]));
          end
          default: begin
            addr_ok_nxt[k] = 1'b0;
          end
        endcase
      end
    end
  end

  // stage one valid follows the parser strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_valid_r <= 1'b0;
    end else begin
      s1_valid_r <= frame_valid;
    end
  end

  // stage one frame type flag, captured every cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      type_ok_r <= 1'b0;
    end else begin
      type_ok_r <= type_ok_nxt;
    end
  end

  // stage one protocol flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      proto_ok_r <= 1'b0;
    end else begin
      proto_ok_r <= proto_ok_nxt;
    end
  end

  // stage one time-to-live flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ttl_ok_r <= 1'b0;
    end else begin
      ttl_ok_r <= ttl_ok_nxt;
    end
  end

  // stage one fragmentation flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frag_ok_r <= 1'b0;
    end else begin
      frag_ok_r <= frag_ok_nxt;
    end
  end

  // stage one options flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_ok_r <= 1'b0;
    end else begin
      opt_ok_r <= opt_ok_nxt;
    end
  end

  // stage one address flags, one bit per slot
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ok_r <= '0;
    end else begin
      addr_ok_r <= addr_ok_nxt;
    end
  end

  // combine: every criterion must pass in the same frame
  always_comb begin
    detail_nxt.frame_type = type_ok_r;
    detail_nxt.proto = proto_ok_r;
    detail_nxt.ttl = ttl_ok_r;
    detail_nxt.frag = frag_ok_r;
    detail_nxt.options = opt_ok_r;
    detail_nxt.src_addr = addr_ok_r[`IACL_SLOT_SRC];
    detail_nxt.dst_addr = addr_ok_r[`IACL_SLOT_DST];
    verdict_hit_nxt = s1_valid_r & (&detail_nxt);
  end

  // stage two valid strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      verdict_valid_r <= 1'b0;
    end else begin
      verdict_valid_r <= s1_valid_r;
    end
  end

  // stage two verdict; hit is low outside a verdict
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      verdict_hit_r <= 1'b0;
    end else begin
      verdict_hit_r <= verdict_hit_nxt;
    end
  end

  // stage two detail, refreshed every cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      detail_r <= '0;
    end else begin
      detail_r <= detail_nxt;
    end
  end

  // hit counter saturates rather than wrapping to a small number
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_count_r <= CNT_W'(`IACL_CNT_RESET);
    end else if (verdict_hit_nxt && !(&hit_count_r)) begin
      hit_count_r <= hit_count_r + CNT_W'(1);
    end
  end

  // outputs straight from flops
  assign verdict_valid = verdict_valid_r;
  assign verdict_hit = verdict_hit_r;
  assign verdict_detail = detail_r;
  assign hit_count = hit_count_r;

endmodule
`default_nettype wire

// >>> hdl/iacl_params.svh
/*
  constants of the ipv4 filter entry matcher: field widths, protocol
  numbers, pipeline depth and reset values.
  assumes inclusion by bare name from the package and the matcher.
*/
`ifndef IACL_PARAMS_SVH
`define IACL_PARAMS_SVH

// header field widths
`define IACL_ADDR_W 32
`define IACL_PROTO_W 8
`define IACL_TTL_W 8
`define IACL_FRAG_OFF_W 13

// well known ipv4 protocol numbers
`define IACL_PROTO_ICMP 8'h01
`define IACL_PROTO_TCP 8'h06
`define IACL_PROTO_UDP 8'h11

// zero values used by the comparisons
`define IACL_TTL_ZERO 8'h00
`define IACL_FRAG_OFF_ZERO 13'h0000

// number of address criteria (source, destination) and their slots
`define IACL_NUM_ADDR 2
`define IACL_SLOT_SRC 0
`define IACL_SLOT_DST 1

// verdict latency in core_clk cycles from frame_valid to verdict_valid
`define IACL_LATENCY 2

// width of the hit counter and its reset value
`define IACL_CNT_W 16
`define IACL_CNT_RESET 16'h0000

`endif

// >>> hdl/iacl_pkg.sv
/*
  types of the ipv4 filter entry matcher: mode encodings, the parsed
  frame header, the entry configuration and the per-criterion result.
  assumes iacl_params.svh on the include path.
*/
`default_nettype none
`include "iacl_params.svh"

package iacl_pkg;

  // protocol filter modes
  typedef enum logic [2:0] {
    IACL_PROTO_ANY,
    IACL_PROTO_SPECIFIC,
    IACL_PROTO_MODE_ICMP,
    IACL_PROTO_MODE_UDP,
    IACL_PROTO_MODE_TCP
  } iacl_proto_mode_t;

  // three way setting: ttl uses no as zero and yes as non-zero
  typedef enum logic [1:0] {
    IACL_TRI_ANY,
    IACL_TRI_NO,
    IACL_TRI_YES
  } iacl_tri_t;

  // address criterion modes
  typedef enum logic [1:0] {
    IACL_ADDR_ANY,
    IACL_ADDR_HOST,
    IACL_ADDR_NETWORK
  } iacl_addr_mode_t;

  // header fields of one parsed frame
  typedef struct packed {
    logic is_ipv4;
    logic [`IACL_PROTO_W-1:0] proto;
    logic [`IACL_TTL_W-1:0] ttl;
    logic more_frag;
    logic [`IACL_FRAG_OFF_W-1:0] frag_off;
    logic has_options;
    logic [`IACL_ADDR_W-1:0] src_addr;
    logic [`IACL_ADDR_W-1:0] dst_addr;
    logic l4_ok;
  } iacl_frame_t;

  // configuration of one filter_entry
  typedef struct packed {
    logic entry_is_ipv4;
    iacl_proto_mode_t proto_mode;
    logic [`IACL_PROTO_W-1:0] proto_val;
    iacl_tri_t ttl_mode;
    iacl_tri_t frag_mode;
    iacl_tri_t opt_mode;
    iacl_addr_mode_t src_mode;
    logic [`IACL_ADDR_W-1:0] src_addr;
    logic [`IACL_ADDR_W-1:0] src_mask;
    iacl_addr_mode_t dst_mode;
    logic [`IACL_ADDR_W-1:0] dst_addr;
    logic [`IACL_ADDR_W-1:0] dst_mask;
  } iacl_cfg_t;

  // per-criterion outcome, one bit each, set means passed
  typedef struct packed {
    logic frame_type;
    logic proto;
    logic ttl;
    logic frag;
    logic options;
    logic src_addr;
    logic dst_addr;
  } iacl_result_t;

endpackage

`default_nettype wire

// >>> dv/iacl_matcher_chk.sv
/*
  checker for the ipv4 filter_entry matcher: timing of the verdict and
  the per-criterion results against the frame and the entry.
  assumes binding to iacl_matcher, one clock, rst_b async active low.
*/
`timescale 1ns/1ps
`default_nettype none

module iacl_matcher_chk
  import iacl_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // frame and entry
  input wire logic frame_valid,
  input wire iacl_frame_t frame,
  input wire iacl_cfg_t cfg,
  // verdict
  input wire logic verdict_valid,
  input wire logic verdict_hit,
  input wire iacl_result_t verdict_detail,
  input wire logic [CNT_W-1:0] hit_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // verdict timing and the overall hit
  property p_lat; frame_valid |-> ##2 verdict_valid; endproperty
  a_lat: assert property (p_lat) else $error("verdict late");
  property p_none; !frame_valid |-> ##2 !verdict_valid; endproperty
  a_none: assert property (p_none) else $error("stray verdict");
  property p_hit; !verdict_valid |-> !verdict_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit w/o valid");
  property p_all; verdict_valid |-> verdict_hit == &verdict_detail;
  endproperty
  a_all: assert property (p_all) else $error("hit not and");
  property p_nonip; frame_valid && !cfg.entry_is_ipv4 |-> ##2 verdict_hit;
  endproperty
  a_nonip: assert property (p_nonip) else $error("non-ipv4");
  property p_cnt; $changed(hit_count) |-> verdict_valid && verdict_hit;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count moved");

  // single criteria, result carried two cycles
  property p_spec; bit v;
    (frame_valid && cfg.entry_is_ipv4 && cfg.proto_mode ==
    IACL_PROTO_SPECIFIC, v = frame.proto == cfg.proto_val)
    |-> ##2 verdict_detail.proto == v; endproperty
  a_spec: assert property (p_spec) else $error("proto");
  property p_ttl; bit v;
    (frame_valid && cfg.entry_is_ipv4 && cfg.ttl_mode == IACL_TRI_NO,
    v = frame.ttl == 8'h00) |-> ##2 verdict_detail.ttl == v; endproperty
  a_ttl: assert property (p_ttl) else $error("ttl");
  property p_frag; bit v;
    (frame_valid && cfg.entry_is_ipv4 && cfg.frag_mode == IACL_TRI_NO,
    v = !(frame.more_frag || frame.frag_off != 13'h0000))
    |-> ##2 verdict_detail.frag == v; endproperty
  a_frag: assert property (p_frag) else $error("frag");
  property p_src; bit v;
    (frame_valid && cfg.entry_is_ipv4 && cfg.src_mode == IACL_ADDR_NETWORK,
    v = ((frame.src_addr ^ cfg.src_addr) & cfg.src_mask) == 32'h0)
    |-> ##2 verdict_detail.src_addr == v; endproperty
  a_src: assert property (p_src) else $error("src net");
  property p_dst; bit v;
    (frame_valid && cfg.entry_is_ipv4 && cfg.dst_mode == IACL_ADDR_HOST,
    v = frame.dst_addr == cfg.dst_addr)
    |-> ##2 verdict_detail.dst_addr == v; endproperty
  a_dst: assert property (p_dst) else $error("dst host");

  // main scenarios
  c_hit: cover property (verdict_valid && verdict_hit);
  c_miss: cover property (verdict_valid && !verdict_hit);
  c_sat: cover property (verdict_hit && &hit_count);
endmodule

`default_nettype wire

// >>> dv/iacl_parser_model.sv
/*
  model of the ingress frame parser: presents one header per cycle.
  assumes the caller steps it at falling edges of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module iacl_parser_model
  import iacl_pkg::*;
(
  // clock
  input wire logic core_clk,
  // header to the matcher
  output logic frame_valid,
  output iacl_frame_t frame
);
  initial begin
    frame_valid = 1'b0;
    frame = '0;
  end

  // present one header for the coming edge
  task automatic send(input iacl_frame_t f);
    @(negedge core_clk);
    frame_valid <= 1'b1;
    frame <= f;
  endtask

  // idle: header lines toggle so stale data never looks held
  task automatic idle();
    @(negedge core_clk);
    frame_valid <= 1'b0;
    frame <= ~frame;
  endtask
endmodule

`default_nettype wire

// >>> dv/iacl_matcher_test.sv
/*
  testbench for the ipv4 filter_entry matcher: random entries and
  frames against a queue model, a mid-run reset, counter saturation.
  assumes the parser model and the checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module iacl_matcher_test
  import iacl_pkg::*;
;
  localparam int CW = 4;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic frame_valid;
  iacl_frame_t frame;
  iacl_cfg_t cfg = '0;
  iacl_cfg_t c;
  iacl_frame_t f;
  logic verdict_valid;
  logic verdict_hit;
  iacl_result_t verdict_detail;
  logic [CW-1:0] hit_count;
  logic [6:0] exp_d;
  logic [6:0] q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int cnt_m = 0;

  always #5 core_clk = ~core_clk;

  iacl_parser_model u_par (.core_clk(core_clk),
    .frame_valid(frame_valid), .frame(frame));
  iacl_matcher #(.CNT_W(CW)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .frame_valid(frame_valid), .frame(frame), .cfg(cfg),
    .verdict_valid(verdict_valid), .verdict_hit(verdict_hit),
    .verdict_detail(verdict_detail), .hit_count(hit_count));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // model of the criteria, one bit each as in the detail
  function automatic bit tri_ok(int m, bit v);
    return m == 0 || (m == 1 && !v) || (m == 2 && v);
  endfunction
  function automatic bit adr_ok(int m, logic [31:0] a, logic [31:0] b,
    logic [31:0] k);
    return m == 0 || (m == 1 && a == b) || (m == 2 && ((a ^ b) & k) == 0);
  endfunction
  function automatic logic [6:0] ref_det(iacl_frame_t x, iacl_cfg_t e);
    int p;
    bit pr;
    p = int'(x.proto);
    case (int'(e.proto_mode))
      0: pr = 1;
      1: pr = x.proto == e.proto_val;
      2: pr = p == 1 && x.l4_ok;
      3: pr = p == 17 && x.l4_ok;
      4: pr = p == 6 && x.l4_ok;
      default: pr = 0;
    endcase
    if (!e.entry_is_ipv4) return 7'h7F;
    return {x.is_ipv4, pr, tri_ok(e.ttl_mode, x.ttl != 0),
      tri_ok(e.frag_mode, x.more_frag || x.frag_off != 0),
      tri_ok(e.opt_mode, x.has_options),
      adr_ok(e.src_mode, x.src_addr, e.src_addr, e.src_mask),
      adr_ok(e.dst_mode, x.dst_addr, e.dst_addr, e.dst_mask)};
  endfunction

  // random entry and frames near it, boundary values included
  function automatic iacl_cfg_t rnd_cfg();
    iacl_cfg_t e;
    e.entry_is_ipv4 = 1'b1;
    e.proto_mode = iacl_proto_mode_t'($urandom_range(4));
    e.proto_val = 8'($urandom);
    e.ttl_mode = iacl_tri_t'($urandom_range(2));
    e.frag_mode = iacl_tri_t'($urandom_range(2));
    e.opt_mode = iacl_tri_t'($urandom_range(2));
    e.src_mode = iacl_addr_mode_t'($urandom_range(2));
    e.dst_mode = iacl_addr_mode_t'($urandom_range(2));
    e.src_addr = $urandom;
    e.dst_addr = $urandom;
    e.src_mask = 32'hFFFFFFFF << $urandom_range(32);
    e.dst_mask = 32'hFFFFFFFF << $urandom_range(32);
    return e;
  endfunction
  function automatic iacl_frame_t rnd_frame(iacl_cfg_t e);
    iacl_frame_t x;
    x.is_ipv4 = $urandom_range(7) != 0;
    case ($urandom_range(3))
      0: x.proto = 8'h01;
      1: x.proto = 8'h06;
      2: x.proto = 8'h11;
      default: x.proto = e.proto_val;
    endcase
    x.ttl = $urandom_range(1) ? 8'h00 : 8'(1 + $urandom_range(254));
    x.more_frag = $urandom_range(3) == 0;
    x.frag_off = $urandom_range(1) ? 13'(1 << $urandom_range(12)) : 13'h0;
    x.has_options = $urandom_range(1);
    x.src_addr = e.src_addr ^ (32'h1 << $urandom_range(40));
    x.dst_addr = e.dst_addr ^ (32'h1 << $urandom_range(40));
    x.l4_ok = $urandom_range(3) != 0;
    return x;
  endfunction

  task automatic put(input iacl_frame_t x);
    u_par.send(x);
    q.push_back(ref_det(x, cfg));
  endtask
  task automatic set_cfg(input iacl_cfg_t e);
    u_par.idle();
    cfg = e;
  endtask

  // compare every verdict with the model
  always @(posedge core_clk) begin
    if (rst_b && verdict_valid) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        exp_d = q.pop_front();
        if (&exp_d && cnt_m < (1 << CW) - 1) cnt_m++;
        chk(verdict_detail.frame_type, exp_d[6]);
        chk(verdict_detail.proto, exp_d[5]);
        chk(verdict_detail.ttl, exp_d[4]);
        chk(verdict_detail.frag, exp_d[3]);
        chk(verdict_detail.options, exp_d[2]);
        chk(verdict_detail.src_addr, exp_d[1]);
        chk(verdict_detail.dst_addr, exp_d[0]);
        chk(verdict_hit, &exp_d);
        chk(hit_count, cnt_m);
      end
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h02f6));
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    repeat (80) begin
      set_cfg(rnd_cfg());
      repeat (8) begin
        put(rnd_frame(cfg));
        if ($urandom_range(1)) u_par.idle();
      end
    end
    $display("test random entries done");
    c = rnd_cfg();
    c.entry_is_ipv4 = 1'b0;
    set_cfg(c);
    repeat (20) put(rnd_frame(cfg));
    $display("test non-ipv4 entry done");
    u_par.idle();
    repeat (4) @(negedge core_clk);
    rst_b = 1'b0;
    @(negedge core_clk);
    chk(hit_count, 32'h0);
    cnt_m = 0;
    rst_b = 1'b1;
    c = '0;
    c.entry_is_ipv4 = 1'b1;
    set_cfg(c);
    repeat (20) begin
      f = rnd_frame(cfg);
      f.is_ipv4 = 1'b1;
      put(f);
    end
    u_par.idle();
    repeat (4) @(negedge core_clk);
    chk(q.size(), 32'h0);
    $display("test reset and counter saturation done");
    print_verdict();
  end

  // watchdog
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule

bind iacl_matcher iacl_matcher_chk #(.CNT_W(CNT_W)) u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .frame_valid(frame_valid),
  .frame(frame), .cfg(cfg), .verdict_valid(verdict_valid),
  .verdict_hit(verdict_hit), .verdict_detail(verdict_detail),
  .hit_count(hit_count));

`default_nettype wire
